// >>> inc/flash_poll_pkg.sv
// Constants and types for the flash status polling controller.
// Assumes a parallel flash with toggle-bit status, driven through its own pins.
package flash_poll_pkg;
   // ==========================================================
   // Data bus bit positions
   localparam int DATA_POLL_POS    = 7;
   localparam int TOGGLE_ONE_POS   = 6;
   localparam int TIMEOUT_FAIL_POS = 5;
   localparam int ERASE_TIMER_POS  = 3;
   localparam int TOGGLE_TWO_POS   = 2;
   // ==========================================================
   // Command data values
   localparam logic [7:0] CMD_RESET = 8'hf0;
   // ==========================================================
   // Bus cycle timing, in clocks of 50 ns
   localparam int CLK_PERIOD_NS  = 50;
   localparam int STROBE_TIME_NS = 100;
   localparam int STROBE_CYCLES  = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_TIME_NS    = 50;
   localparam int GAP_CYCLES     = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Timer reset value for cycle counter
   localparam logic [3:0] COUNT_ZERO = 4'h0;
   // ==========================================================
   // Polling results
   typedef enum logic [1:0] {RES_DONE, RES_FAIL, RES_TIMER_SET, RES_NONE} poll_result_t;
endpackage : flash_poll_pkg

// >>> inc/flash_cycle_if.sv
// Interface carrying single bus cycle requests from the poller to the cycle engine.
// Assumes one clock domain shared by both modules.
`timescale 1ns/1ps
interface flash_cycle_if;
   logic       req;      // Start a cycle
   logic       write;    // 1 write, 0 read
   logic [17:0] addr;
   logic [7:0] wdata;
   logic       done;     // One-cycle pulse at end of cycle
   logic [7:0] rdata;    // Sampled read data
   modport master (output req, output write, output addr, output wdata,
                   input done, input rdata);
   modport engine (input req, input write, input addr, input wdata,
                   output done, output rdata);
endinterface : flash_cycle_if

// >>> hw/flash_cycle_engine.sv
// Runs one flash read or write cycle on the device pins per request.
// Assumes the flash samples on strobe edges and data input is synchronous to clk.
`timescale 1ns/1ps
module flash_cycle_engine (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   flash_cycle_if.engine    cyc,
   output logic [17:0]      flash_addr,
   output logic             chip_enable_n,
   output logic             output_enable_n,
   output logic             write_strobe_n,
   input  wire logic [7:0]  data_bus_in,
   output logic [7:0]       data_bus_out,
   output logic             data_bus_oe
);
   import flash_poll_pkg::*;
   typedef enum logic [1:0] {E_IDLE, E_STROBE, E_GAP} eng_state_t;
   eng_state_t state, next_state;
   logic [3:0] count, next_count;
   logic       is_write, next_is_write;
   logic [7:0] rdata, next_rdata;
   logic [17:0] next_addr;
   logic [7:0]  next_wdata;
   localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYCLES - 1);
   localparam logic [3:0] GAP_LAST    = 4'(GAP_CYCLES - 1);

   // The four-bit phase counter must hold both phase lengths
   if (STROBE_CYCLES < 1 || STROBE_CYCLES > 16
       || GAP_CYCLES < 1 || GAP_CYCLES > 16) begin : g_bad_timing
      $error("Strobe or gap length outside the phase counter range");
   end

   // ==========================================================
   // Next state of the cycle sequencer
   always_comb begin
      next_state    = state;
      next_count    = count;
      next_is_write = is_write;
      next_rdata    = rdata;
      next_addr     = flash_addr;
      next_wdata    = data_bus_out;
      case (state)
         E_IDLE: begin
            if (cyc.req) begin
               next_state    = E_STROBE;
               next_count    = COUNT_ZERO;
               next_is_write = cyc.write;
               next_addr     = cyc.addr;
               next_wdata    = cyc.wdata;
            end
         end
         E_STROBE: begin
            if (count == STROBE_LAST) begin
               next_state = E_GAP;
               next_count = COUNT_ZERO;
               if (!is_write)
                  next_rdata = data_bus_in; // Sample before OE rises; counts as status read
            end else
               next_count = count + 4'h1;
         end
         E_GAP: begin
            if (count == GAP_LAST)
               next_state = E_IDLE;
            else
               next_count = count + 4'h1;
         end
         default: next_state = E_IDLE;
      endcase
   end

   // Register sequencer state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state        <= E_IDLE;
         count        <= COUNT_ZERO;
         is_write     <= 1'b0;
         rdata        <= 8'h00;
         flash_addr   <= 18'h00000;
         data_bus_out <= 8'h00;
      end else begin
         state        <= next_state;
         count        <= next_count;
         is_write     <= next_is_write;
         rdata        <= next_rdata;
         flash_addr   <= next_addr;
         data_bus_out <= next_wdata;
      end
   end

   // Pin strobes; the data bus is driven only during a write (enable low = drive)
   assign chip_enable_n   = (state != E_STROBE);
   assign output_enable_n = !(state == E_STROBE && !is_write);
   assign write_strobe_n  = !(state == E_STROBE && is_write);
   assign data_bus_oe     = !(state != E_IDLE && is_write);
   assign cyc.done        = (state == E_GAP) && (count == GAP_LAST);
   assign cyc.rdata       = rdata;

   a_strobe_excl: assert property (@(posedge clk) disable iff (sys_rst)
      !(!output_enable_n && !write_strobe_n))
      else $error("Read and write strobes active together");
   a_done_after_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      cyc.done |-> !$past(chip_enable_n, GAP_CYCLES) && chip_enable_n)
      else $error("Cycle done without a gap");
endmodule : flash_cycle_engine

// >>> hw/flash_status_poller.sv
// Host-side poller: runs the toggle-bit and sector erase timer checks on a flash.
// Assumes the user has already written the program or erase command sequence.
`timescale 1ns/1ps
module flash_status_poller (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       poll_start,
   input  wire logic                       timer_check,
   input  wire logic                       use_toggle_two,
   input  wire logic [17:0]                status_addr,
   output logic                            busy,
   output logic                            result_valid,
   output flash_poll_pkg::poll_result_t    result,
   output logic                            sector_erasing,
   output logic                            erase_suspended,
   output logic [17:0]                     flash_addr,
   output logic                            chip_enable_n,
   output logic                            output_enable_n,
   output logic                            write_strobe_n,
   input  wire logic [7:0]                 data_bus_in,
   output logic [7:0]                      data_bus_out,
   output logic                            data_bus_oe
);
   import flash_poll_pkg::*;
   typedef enum logic [2:0] {
      S_IDLE, S_READ_FIRST, S_READ_NEXT, S_RECHECK, S_RESET_WR, S_TIMER_RD, S_REPORT
   } poll_state_t;

   flash_cycle_if cyc ();
   flash_cycle_engine u_engine (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .cyc             (cyc.engine),
      .flash_addr      (flash_addr),
      .chip_enable_n   (chip_enable_n),
      .output_enable_n (output_enable_n),
      .write_strobe_n  (write_strobe_n),
      .data_bus_in     (data_bus_in),
      .data_bus_out    (data_bus_out),
      .data_bus_oe     (data_bus_oe)
   );

   poll_state_t  state, next_state;
   logic         prev_bit, next_prev_bit;
   logic         prev_two, next_prev_two;
   logic         sel_two, next_sel_two;
   logic [17:0]  addr, next_addr;
   logic         issued, next_issued;
   poll_result_t next_result;
   logic         next_valid, next_erasing, next_suspended;

   // Toggle bit being watched: bit one, or bit two for sector status
   function automatic logic watched(input logic [7:0] d, input logic two);
      return two ? d[TOGGLE_TWO_POS] : d[TOGGLE_ONE_POS];
   endfunction : watched

   logic rd_bit;
   assign rd_bit = watched(cyc.rdata, sel_two);

   // ==========================================================
   // Polling sequence
   always_comb begin
      next_state     = state;
      next_prev_bit  = prev_bit;
      next_prev_two  = prev_two;
      next_sel_two   = sel_two;
      next_addr      = addr;
      next_issued    = issued;
      next_result    = result;
      next_valid     = 1'b0;
      next_erasing   = sector_erasing;
      next_suspended = erase_suspended;
      cyc.req        = 1'b0;
      cyc.write      = 1'b0;
      cyc.addr       = addr;                 // Status address inside the sector
      cyc.wdata      = CMD_RESET;
      case (state)
         S_IDLE: begin
            if (poll_start) begin
               next_state   = S_READ_FIRST;  // Always restart at the first double read
               next_addr    = status_addr;
               next_sel_two = use_toggle_two;
               next_issued  = 1'b0;
            end else if (timer_check) begin
               // Timer bit is read only on a request in idle with poll_start low
               next_state  = S_TIMER_RD;
               next_addr   = status_addr;
               next_issued = 1'b0;
            end
         end
         S_READ_FIRST: begin
            cyc.req     = !issued;
            next_issued = 1'b1;
            if (cyc.done) begin
               next_prev_bit = rd_bit;       // Store first sample
               next_prev_two = cyc.rdata[TOGGLE_TWO_POS];
               next_issued   = 1'b0;
               next_state    = S_READ_NEXT;
            end
         end
         S_READ_NEXT: begin
            cyc.req     = !issued;
            next_issued = 1'b1;
            if (cyc.done) begin
               next_issued   = 1'b0;
               next_prev_bit = rd_bit;
               next_prev_two = cyc.rdata[TOGGLE_TWO_POS];
               // Mode from bit one, sector from bit two
               next_suspended = (cyc.rdata[TOGGLE_ONE_POS] == prev_bit) && !sel_two
                                && (cyc.rdata[TOGGLE_TWO_POS] != prev_two);
               next_erasing   = (cyc.rdata[TOGGLE_TWO_POS] != prev_two);
               if (rd_bit == prev_bit) begin
                  next_result = RES_DONE;    // Stopped toggling: finished
                  next_state  = S_REPORT;
               end else if (cyc.rdata[TIMEOUT_FAIL_POS])
                  next_state  = S_RECHECK;   // Fail bit high: check again
            end
         end
         S_RECHECK: begin
            cyc.req     = !issued;
            next_issued = 1'b1;
            if (cyc.done) begin
               next_issued = 1'b0;
               if (rd_bit == prev_bit) begin
                  next_result = RES_DONE;
                  next_state  = S_REPORT;
               end else begin
                  next_result = RES_FAIL;    // Still toggling: reset the device
                  next_state  = S_RESET_WR;
               end
            end
         end
         S_RESET_WR: begin
            cyc.req     = !issued;
            cyc.write   = 1'b1;              // Single write of f0, any address
            next_issued = 1'b1;
            if (cyc.done) begin
               next_issued = 1'b0;
               next_state  = S_REPORT;
            end
         end
         S_TIMER_RD: begin
            cyc.req     = !issued;
            next_issued = 1'b1;
            if (cyc.done) begin
               next_issued = 1'b0;
               // Timer bit 1: erase started, added commands may be lost
               next_result = cyc.rdata[ERASE_TIMER_POS] ? RES_TIMER_SET : RES_NONE;
               next_state  = S_REPORT;
            end
         end
         S_REPORT: begin
            next_valid = 1'b1;
            next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   // Register polling state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state           <= S_IDLE;
         prev_bit        <= 1'b0;
         prev_two        <= 1'b0;
         sel_two         <= 1'b0;
         addr            <= 18'h00000;
         issued          <= 1'b0;
         result          <= RES_NONE;
         result_valid    <= 1'b0;
         sector_erasing  <= 1'b0;
         erase_suspended <= 1'b0;
      end else begin
         state           <= next_state;
         prev_bit        <= next_prev_bit;
         prev_two        <= next_prev_two;
         sel_two         <= next_sel_two;
         addr            <= next_addr;
         issued          <= next_issued;
         result          <= next_result;
         result_valid    <= next_valid;
         sector_erasing  <= next_erasing;
         erase_suspended <= next_suspended;
      end
   end

   assign busy = (state != S_IDLE);

   a_fail_resets: assert property (@(posedge clk) disable iff (sys_rst)
      (state == S_RECHECK && next_state == S_RESET_WR) |=> result == RES_FAIL)
      else $error("Failure did not lead to reset write");
   a_reset_data: assert property (@(posedge clk) disable iff (sys_rst)
      !write_strobe_n |-> data_bus_out == CMD_RESET && !data_bus_oe)
      else $error("Reset write carries wrong data");
   a_start_first: assert property (@(posedge clk) disable iff (sys_rst)
      (state == S_IDLE && poll_start) |=> state == S_READ_FIRST)
      else $error("Poll did not restart at first read");
   a_two_reads: assert property (@(posedge clk) disable iff (sys_rst)
      (state == S_READ_NEXT && $past(state) == S_READ_FIRST) |-> !issued)
      else $error("Second read not fresh");
   a_done_report: assert property (@(posedge clk) disable iff (sys_rst)
      (state == S_READ_NEXT && cyc.done && rd_bit == prev_bit) |=> ##1 result_valid)
      else $error("Finished poll not reported");
   a_recheck_fail: assert property (@(posedge clk) disable iff (sys_rst)
      (state == S_READ_NEXT && cyc.done && rd_bit != prev_bit
       && cyc.rdata[TIMEOUT_FAIL_POS]) |=> state == S_RECHECK)
      else $error("Fail bit did not trigger recheck");
   a_timer_result: assert property (@(posedge clk) disable iff (sys_rst)
      (state == S_TIMER_RD && cyc.done) |=> result == (cyc.rdata[ERASE_TIMER_POS]
       ? RES_TIMER_SET : RES_NONE))
      else $error("Timer result wrong");
   a_status_addr: assert property (@(posedge clk) disable iff (sys_rst)
      !chip_enable_n |-> flash_addr == addr)
      else $error("Status read left the sector");
endmodule : flash_status_poller

// >>> tb/flash_device_model.sv
// Behavioural parallel flash answering status reads and reset writes.
// Assumes active-low strobes from the controller and one shared clock.
`timescale 1ns/1ps
module flash_device_model (
   input  wire logic        clk,
   input  wire logic [17:0] flash_addr,
   input  wire logic        chip_enable_n,
   input  wire logic        output_enable_n,
   input  wire logic        write_strobe_n,
   input  wire logic [7:0]  data_bus_out,
   input  wire logic        data_bus_oe,
   output logic      [7:0]  data_bus_in
);
   // ==========================================================
   // State: op 0 array, 1 program, 2 erase, 3 erase suspend
   localparam logic [7:0] ARRAY_BYTE = 8'h7f;
   localparam int         WIN_CYC    = 40;
   int         op, left, fail_at, reads, writes, win;
   logic       tog1, tog2, fail, timer;
   logic [4:0] sect;
   logic [7:0] last, stat, wlast;
   wire rd     = !chip_enable_n && !output_enable_n;
   wire wr     = !chip_enable_n && !write_strobe_n;
   wire in_sec = flash_addr[17:13] == sect;
   // Status byte seen on a read
   always_comb begin
      case (op)
         1: stat = {1'b1, tog1, fail, 5'h00};
         2: stat = {1'b0, tog1, fail, 1'b0, timer, tog2 & in_sec, 2'h0};
         3: stat = in_sec ? {1'b1, tog1, 3'h0, tog2, 2'h0} : ARRAY_BYTE;
         default: stat = ARRAY_BYTE;
      endcase
   end
   // Released bus shows the inverse of the last value
   assign data_bus_in = rd ? stat : ~last;
   // Either strobe ending the read advances the toggle bits
   always @(negedge rd) begin
      last = stat;
      reads++;
      if (op == 1 || op == 2) tog1 = ~tog1;
      if (op >= 2 && in_sec) tog2 = ~tog2;
      if (op != 3 && reads >= fail_at) fail = 1'b1;
      if (left > 0) begin
         left--;
         if (left == 0) op = 0;
      end
   end
   // Write cycle: only the reset command is acted upon
   always @(negedge wr) begin
      writes++;
      wlast = data_bus_out;
      if (!data_bus_oe && data_bus_out == 8'hf0) begin
         op   = 0;
         fail = 1'b0;
      end
   end
   // Sector erase acceptance window
   always @(posedge clk) begin
      if (op == 2 && !timer) begin
         win++;
         if (win >= WIN_CYC) timer <= 1'b1;
      end
   end
   // Command sequence just finished: status valid from now on
   task start_op(input int k, input int n, input int f, input logic [4:0] s);
      op      = k;
      left    = n;
      fail_at = f;
      sect    = s;
      tog1    = 0;
      tog2    = 0;
      fail    = 0;
      timer   = 0;
      win     = 0;
      reads   = 0;
      writes  = 0;
   endtask : start_op
   // Additional sector erase command
   task add_sector(output logic acc);
      acc = (op == 2 && !timer);
      if (acc) win = 0;
   endtask : add_sector
   initial begin
      last = 8'h00;
      start_op(0, 0, 1000, 5'h00);
   end
endmodule : flash_device_model

// >>> tb/flash_write_status_reporting_test.sv
// Self-checking bench for the flash status poller.
// Assumes the behavioural flash model in tb/ on the controller's pins.
`timescale 1ns/1ps
`define CHK(a, e) begin \
   checked++; \
   if ((a) !== (e)) begin \
      miscompares++; \
      $display("wrong value at %0t: got %0h want %0h", $time, (a), (e)); \
   end \
end
module flash_write_status_reporting_test;
   import flash_poll_pkg::*;
   // ==========================================================
   // Signals
   logic         clk = 1'b0, sys_rst = 1'b1;
   logic         poll_start = 1'b0, timer_check = 1'b0, use_toggle_two = 1'b0;
   logic [17:0]  status_addr = 18'h00000, flash_addr;
   logic         busy, result_valid, sector_erasing, erase_suspended;
   logic         chip_enable_n, output_enable_n, write_strobe_n, data_bus_oe, acc;
   logic [7:0]   data_bus_in, data_bus_out;
   poll_result_t result;
   int           miscompares = 0, checked = 0, lat;
   // Clock at 20 MHz
   always #25 clk = ~clk;
   flash_status_poller flash_status_poller_i (.clk(clk), .sys_rst(sys_rst),
      .poll_start(poll_start), .timer_check(timer_check), .use_toggle_two(use_toggle_two),
      .status_addr(status_addr), .busy(busy), .result_valid(result_valid), .result(result),
      .sector_erasing(sector_erasing), .erase_suspended(erase_suspended),
      .flash_addr(flash_addr), .chip_enable_n(chip_enable_n),
      .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
   flash_device_model flash_device_model_i (.clk(clk), .flash_addr(flash_addr),
      .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
      .write_strobe_n(write_strobe_n), .data_bus_out(data_bus_out),
      .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in));
   // ==========================================================
   // Shared tasks
   task close_out;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   // One request, then a bounded wait for the answer pulse
   task run(input logic tmr, input logic t2, input logic [17:0] a);
      @(posedge clk);
      poll_start     <= !tmr;
      timer_check    <= tmr;
      use_toggle_two <= t2;
      status_addr    <= a;
      @(posedge clk);
      poll_start  <= 1'b0;
      timer_check <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
         if (lat == 1)
            `CHK(busy, 1'b1)
      end while (result_valid !== 1'b1 && lat < 400);
      if (lat >= 400) begin
         miscompares++;
         $display("wrong value at %0t: no answer", $time);
      end
   endtask : run
   // ==========================================================
   // Scenarios
   task t_prog; // Program toggling six reads; a timer check while busy is ignored
      flash_device_model_i.start_op(1, 6, 1000, 5'h00);
      fork
         run(1'b0, 1'b0, 18'h01234);
         begin
            repeat (5) @(posedge clk);
            timer_check <= 1'b1;
            @(posedge clk);
            timer_check <= 1'b0;
         end
      join
      `CHK(result, RES_DONE)
      `CHK(flash_device_model_i.reads, 7)
      `CHK(flash_device_model_i.writes, 0)
      $display("t_prog done");
   endtask : t_prog
   task t_fail; // Toggling with the fail bit never stops
      flash_device_model_i.start_op(1, 0, 1, 5'h00);
      run(1'b0, 1'b0, 18'h02000);
      `CHK(result, RES_FAIL)
      `CHK(flash_device_model_i.writes, 1)
      `CHK(flash_device_model_i.wlast, 8'hf0)
      `CHK(flash_device_model_i.op, 0)
      flash_device_model_i.start_op(1, 2, 1, 5'h00);
      run(1'b0, 1'b0, 18'h02000);
      `CHK(result, RES_DONE)
      `CHK(flash_device_model_i.writes, 0)
      $display("t_fail done");
   endtask : t_fail
   task t_erase; // Toggle bit two inside and outside the erased sector
      flash_device_model_i.start_op(2, 0, 1000, 5'h01);
      run(1'b0, 1'b1, 18'h04000);
      `CHK(result, RES_DONE)
      `CHK(flash_device_model_i.reads, 2)
      `CHK(sector_erasing, 1'b0)
      flash_device_model_i.start_op(2, 4, 1000, 5'h01);
      run(1'b0, 1'b1, 18'h02010);
      `CHK(result, RES_DONE)
      `CHK(flash_device_model_i.reads, 5)
      flash_device_model_i.start_op(3, 0, 1000, 5'h01);
      run(1'b0, 1'b0, 18'h02010);
      `CHK(result, RES_DONE)
      `CHK(erase_suspended, 1'b1)
      `CHK(sector_erasing, 1'b1)
      $display("t_erase done");
   endtask : t_erase
   task t_timer; // Acceptance window, its restart and its expiry
      flash_device_model_i.start_op(2, 0, 1000, 5'h01);
      run(1'b1, 1'b0, 18'h02000);
      `CHK(result, RES_NONE)
      `CHK(lat <= 8, 1'b1)
      repeat (25) @(posedge clk);
      flash_device_model_i.add_sector(acc);
      `CHK(acc, 1'b1)
      repeat (25) @(posedge clk);
      run(1'b1, 1'b0, 18'h02000);
      `CHK(result, RES_NONE)
      repeat (50) @(posedge clk);
      run(1'b1, 1'b0, 18'h02000);
      `CHK(result, RES_TIMER_SET)
      flash_device_model_i.add_sector(acc);
      `CHK(acc, 1'b0)
      $display("t_timer done");
   endtask : t_timer
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_prog;
      t_fail;
      t_erase;
      t_timer;
      close_out;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      close_out;
   end
endmodule : flash_write_status_reporting_test
